// *** rtl/line_adapter_cfg.svh ***
// Purpose: constants for the four-line asynchronous serial adapter
// Assumes: 25 MHz system clock, APB register access, 32-bit data
// Notes: every register takes one aligned word
// Summary of operation
// - Four lines, each full or half duplex
// - Start/stop signalling, up to 19200 bps
// - Start, 5-8 data, parity, 1-2 stops
// - Data bits sent and received LSB first
// - Idle transmitter holds line at mark
// - Receiver aligns per character on start bit
// - Line register contents kept; firmware maps them
// - Each line has own control/status registers
// - Extra registers reachable without channel programs
// - New features only in formerly unused bits
// - Speed code bits 4-7 select 50..19200 bps
// - Two-bit field selects five to eight bits
// - Stop bit: 1, or 1.5/2 when set
// - Overrun and framing error status bits
`ifndef LINE_ADAPTER_CFG_SVH
`define LINE_ADAPTER_CFG_SVH

`define CLK_HZ 25000000
`define NUM_LINES 4
`define OVERSAMPLE 16
// Per-line block of eight words starting at line*0x20
`define LINE_STRIDE_SHIFT 5
`define OFS_DATA 8'h04
`define OFS_CTRL 8'h08
`define OFS_STAT 8'h14
`define OFS_SPEED 8'h10
`define OFS_CFG 8'h18
// Global registers: interrupt status, interrupt mask, identity
`define OFS_IRQ_STAT 8'h80
`define OFS_IRQ_MASK 8'h84
`define OFS_ID 8'h88
`define ID_VALUE 8'h5C // Arbitrary identity value, names no part
// Control register bits
`define CTRL_RTS 1
`define CTRL_SPACE 3
`define CTRL_MARK 4
`define CTRL_LOOP 5
`define CTRL_RX_ON 6
`define CTRL_TX_ON 7
// Config register stop bit; parity bits sit in the register written at the status address
`define CFG_STOP 4
`define CFG_PAR_TYPE 2
`define CFG_PAR_EN 3
// Status register bits
`define STAT_CTS 1
`define STAT_TX_EMPTY 4
`define STAT_RX_FULL 5
`define STAT_OVERRUN 6
`define STAT_FRAMING 7
// Reset values
`define CTRL_RESET 8'h00
`define SPEED_RESET 8'hE0
`define CFG_RESET 8'h03
`define PAR_RESET 8'h00

`endif

// *** rtl/line_adapter_pkg.sv ***
// Purpose: shared types of the serial adapter
// Assumes: constants come from line_adapter_cfg.svh
// Notes: types only
package line_adapter_pkg;
	// Per-line settings seen by the serial engine
	typedef struct packed {
		logic [15:0] tick_div; // System clocks per sixteenth of a bit, minus one
		logic [1:0] size; // Character size code
		logic stop_two; // Longer stop selected
		logic par_en; // Parity on
		logic par_even; // Even parity when set
		logic tx_on; // Transmitter enabled
		logic rx_on; // Receiver enabled
		logic force_space; // Break
		logic force_mark; // Hold mark
		logic loop; // Internal loop
	} line_cfg_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;
endpackage : line_adapter_pkg

// *** rtl/line_link_if.sv ***
// Purpose: bundle between register file and one serial engine
// Assumes: single clock
// Notes: strobes are one-cycle pulses
`timescale 1ns/1ps
interface line_link_if;
	import line_adapter_pkg::*;
	line_cfg_t cfg; // Settings
	logic tx_load; // Write strobe of a character
	logic [7:0] tx_data; // Character to send
	logic tx_busy; // Engine holds a character
	logic rx_valid; // Received character pulse
	logic [7:0] rx_data; // Received character
	logic rx_frame_err; // Missing stop flag, valid with rx_valid, held until the next character
	logic rx_par_err; // Parity mismatch flag, valid with rx_valid, held until the next character
	modport regs (output cfg, tx_load, tx_data, input tx_busy, rx_valid, rx_data,
		rx_frame_err, rx_par_err);
	modport engine (input cfg, tx_load, tx_data, output tx_busy, rx_valid, rx_data,
		rx_frame_err, rx_par_err);
endinterface : line_link_if

// *** rtl/serial_line_engine.sv ***
// Purpose: one line's transmitter and receiver
// Assumes: 16x oversampling ticks from the configured divider
// Notes: 1.5 stops only for 5-bit characters
`timescale 1ns/1ps
`include "line_adapter_cfg.svh"
module serial_line_engine
	import line_adapter_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Serial pins
	input wire logic rxd_in,
	output logic txd_out,
	// Register side
	line_link_if.engine link
);
	// All engine state
	typedef struct packed {
		logic [15:0] div_cnt;
		tx_state_t tx_st;
		logic [3:0] tx_sub;
		logic [3:0] tx_bit;
		logic [8:0] tx_sh;
		logic txd;
		rx_state_t rx_st;
		logic [3:0] rx_sub;
		logic [3:0] rx_bit;
		logic [8:0] rx_sh;
		logic rx_valid;
		logic fe;
		logic pe;
		logic [7:0] rx_out;
	} eng_t;
	eng_t s_reg, s_next;
	logic tick;
	logic rxd;
	logic [3:0] nbits;

	// Data bits for the size code
	function automatic logic [3:0] data_bits(input logic [1:0] code);
		data_bits = 4'h5 + {2'h0, code};
	endfunction : data_bits

	// Parity over the low bits of a character
	function automatic logic parity_of(input logic [7:0] d, input logic [1:0] code,
		input logic even);
		logic [7:0] m;
		m = 8'hFF >> (3'h3 - {1'b0, code});
		parity_of = (^(d & m)) ^ ~even;
	endfunction : parity_of

	assign tick = (s_reg.div_cnt == 16'h0000);
	// Loop path takes our own output; mark held outward while looping
	assign rxd = link.cfg.loop ? s_reg.txd : rxd_in;
	assign nbits = data_bits(link.cfg.size) + {3'h0, link.cfg.par_en};

	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.rx_valid = 1'b0;
		s_next.div_cnt = tick ? link.cfg.tick_div : s_reg.div_cnt - 16'h0001;
		// Transmitter
		unique case (s_reg.tx_st)
			TX_IDLE: begin
				s_next.txd = 1'b1;
				if (link.tx_load && link.cfg.tx_on) begin
					s_next.tx_sh = {parity_of(link.tx_data, link.cfg.size, link.cfg.par_even),
						8'h00};
					s_next.tx_sh = s_next.tx_sh | ({1'b0, link.tx_data} &
						(9'h0FF >> (3'h3 - {1'b0, link.cfg.size})));
					if (link.cfg.par_en)
						s_next.tx_sh[data_bits(link.cfg.size)] = s_next.tx_sh[8];
					s_next.tx_st = TX_START;
					s_next.tx_sub = 4'h0;
				end
			end
			TX_START: if (tick) begin
				s_next.txd = 1'b0;
				s_next.tx_sub = s_reg.tx_sub + 4'h1;
				if (s_reg.tx_sub == 4'hF) begin
					s_next.tx_st = TX_BITS;
					s_next.tx_bit = 4'h0;
				end
			end
			TX_BITS: if (tick) begin
				s_next.txd = s_reg.tx_sh[0];
				s_next.tx_sub = s_reg.tx_sub + 4'h1;
				if (s_reg.tx_sub == 4'hF) begin
					s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
					s_next.tx_bit = s_reg.tx_bit + 4'h1;
					if (s_reg.tx_bit == nbits - 4'h1) begin
						s_next.tx_st = TX_STOP;
						s_next.tx_bit = 4'h0;
					end
				end
			end
			TX_STOP: if (tick) begin
				s_next.txd = 1'b1;
				s_next.tx_sub = s_reg.tx_sub + 4'h1;
				if (s_reg.tx_sub == 4'hF)
					s_next.tx_bit = s_reg.tx_bit + 4'h1;
				// Half-bit end for 1.5 stops, full second bit otherwise
				if (!link.cfg.stop_two && s_reg.tx_sub == 4'hF)
					s_next.tx_st = TX_IDLE;
				else if (link.cfg.stop_two && link.cfg.size == 2'b00 &&
					s_reg.tx_bit == 4'h1 && s_reg.tx_sub == 4'h7)
					s_next.tx_st = TX_IDLE;
				else if (link.cfg.stop_two && s_reg.tx_bit == 4'h1 && s_reg.tx_sub == 4'hF)
					s_next.tx_st = TX_IDLE;
			end
		endcase
		// Receiver: wait for falling edge, confirm at mid start bit
		unique case (s_reg.rx_st)
			RX_IDLE: if (tick && link.cfg.rx_on && !rxd) begin
				s_next.rx_st = RX_START;
				s_next.rx_sub = 4'h0;
			end
			RX_START: if (tick) begin
				s_next.rx_sub = s_reg.rx_sub + 4'h1;
				if (s_reg.rx_sub == 4'h7) begin
					s_next.rx_sub = 4'h0;
					s_next.rx_bit = 4'h0;
					s_next.rx_sh = 9'h000;
					s_next.rx_st = rxd ? RX_IDLE : RX_BITS;
				end
			end
			RX_BITS: if (tick) begin
				s_next.rx_sub = s_reg.rx_sub + 4'h1;
				if (s_reg.rx_sub == 4'hF) begin
					s_next.rx_sh[s_reg.rx_bit] = rxd;
					s_next.rx_bit = s_reg.rx_bit + 4'h1;
					if (s_reg.rx_bit == nbits - 4'h1)
						s_next.rx_st = RX_STOP;
				end
			end
			RX_STOP: if (tick) begin
				s_next.rx_sub = s_reg.rx_sub + 4'h1;
				if (s_reg.rx_sub == 4'hF) begin
					s_next.rx_st = RX_IDLE;
					s_next.rx_valid = 1'b1;
					s_next.fe = !rxd;
					s_next.rx_out = s_reg.rx_sh[7:0] &
						(8'hFF >> (3'h3 - {1'b0, link.cfg.size}));
					s_next.pe = link.cfg.par_en &&
						(s_reg.rx_sh[data_bits(link.cfg.size)] !=
						parity_of(s_reg.rx_sh[7:0], link.cfg.size, link.cfg.par_even));
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_reg <= '0;
			s_reg.txd <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Line drive: break and mark overrides; loop keeps the pin at mark
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			txd_out <= 1'b1;
		else if (link.cfg.force_space && !link.cfg.loop)
			txd_out <= 1'b0;
		else
			txd_out <= link.cfg.force_mark || link.cfg.loop || s_next.txd;
	end

	assign link.tx_busy = (s_reg.tx_st != TX_IDLE);
	assign link.rx_valid = s_reg.rx_valid;
	assign link.rx_data = s_reg.rx_out;
	assign link.rx_frame_err = s_reg.fe;
	assign link.rx_par_err = s_reg.pe;
endmodule : serial_line_engine

// *** rtl/async_line_adapter.sv ***
// Purpose: four-line asynchronous adapter with APB register file
// Assumes: APB slave, zero wait states, one aligned word per register
// Notes: each line has its own register group; firmware maps line registers
`timescale 1ns/1ps
`include "line_adapter_cfg.svh"
module async_line_adapter
	import line_adapter_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Serial lines
	input wire logic [3:0] rxd_in,
	output logic [3:0] txd_out,
	// Interrupt
	output logic irq_out
);
	// Register state of the whole block
	typedef struct packed {
		logic [3:0][7:0] ctrl;
		logic [3:0][7:0] speed;
		logic [3:0][7:0] cfg;
		logic [3:0][7:0] par;
		logic [3:0][7:0] rx_data;
		logic [3:0] rx_full;
		logic [3:0] ovr;
		logic [3:0] fe;
		logic [3:0] pe;
		logic [15:0] irq_stat;
		logic [15:0] irq_mask;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic irq;
	} regs_t;
	regs_t r_reg, r_next;
	line_link_if link [`NUM_LINES] ();
	logic [3:0] tx_busy;
	logic [3:0] rx_valid;
	logic [3:0] rx_fe;
	logic [3:0] rx_pe;
	logic [3:0][7:0] rx_byte;
	logic [3:0] tx_load;
	logic [7:0] tx_byte;
	logic setup;
	logic [1:0] line_sel;
	logic [4:0] ofs;

	// System clocks per sixteenth-bit for each speed code (period minus one)
	function automatic logic [15:0] speed_div(input logic [3:0] code);
		logic [31:0] bps100;
		unique case (code)
			4'h0: bps100 = 32'd5000;
			4'h1: bps100 = 32'd7500;
			4'h2: bps100 = 32'd11000;
			4'h3: bps100 = 32'd13450;
			4'h4: bps100 = 32'd15000;
			4'h5: bps100 = 32'd20000;
			4'h6: bps100 = 32'd30000;
			4'h7: bps100 = 32'd60000;
			4'h8: bps100 = 32'd105000;
			4'h9: bps100 = 32'd120000;
			4'hA: bps100 = 32'd180000;
			4'hB: bps100 = 32'd200000;
			4'hC: bps100 = 32'd240000;
			4'hD: bps100 = 32'd480000;
			4'hE: bps100 = 32'd960000;
			4'hF: bps100 = 32'd1920000;
		endcase
		speed_div = 16'((64'(`CLK_HZ) * 64'd100 / (64'(bps100) * `OVERSAMPLE)) - 64'd1);
	endfunction : speed_div

	// One serial engine per line, each wholly independent
	for (genvar i = 0; i < `NUM_LINES; i++) begin : g_line
		assign link[i].cfg = '{
			tick_div: speed_div(r_reg.speed[i][7:4]),
			size: r_reg.cfg[i][1:0],
			stop_two: r_reg.cfg[i][`CFG_STOP],
			par_en: r_reg.par[i][`CFG_PAR_EN],
			par_even: r_reg.par[i][`CFG_PAR_TYPE],
			tx_on: r_reg.ctrl[i][`CTRL_TX_ON],
			rx_on: r_reg.ctrl[i][`CTRL_RX_ON],
			force_space: r_reg.ctrl[i][`CTRL_SPACE],
			force_mark: r_reg.ctrl[i][`CTRL_MARK],
			loop: r_reg.ctrl[i][`CTRL_LOOP]};
		assign link[i].tx_load = tx_load[i];
		assign link[i].tx_data = tx_byte;
		assign tx_busy[i] = link[i].tx_busy;
		assign rx_valid[i] = link[i].rx_valid;
		assign rx_byte[i] = link[i].rx_data;
		assign rx_fe[i] = link[i].rx_frame_err;
		assign rx_pe[i] = link[i].rx_par_err;
		serial_line_engine u_eng (
			.sys_clk_in(sys_clk_in),
			.reset_in(reset_in),
			.rxd_in(rxd_in[i]),
			.txd_out(txd_out[i]),
			.link(link[i])
		);
	end

	// Address decode: line groups below 0x80, globals above
	assign setup = psel_in && !penable_in;
	assign line_sel = paddr_in[6:5];
	assign ofs = paddr_in[4:0];
	assign tx_byte = pwdata_in[7:0];
	always_comb begin
		tx_load = 4'h0;
		if (setup && pwrite_in && !paddr_in[7] && {3'h0, ofs} == `OFS_DATA)
			tx_load[line_sel] = 1'b1;
	end

	// Next register state
	always_comb begin
		logic [15:0] ev;
		logic [7:0] rd;
		ev = 16'h0000;
		rd = 8'h00;
		r_next = r_reg;
		// Answer in the cycle after setup, one wait-free access phase
		r_next.ready = setup;
		r_next.err = 1'b0;
		// Receive path: a new character over an unread one is an overrun
		for (int i = 0; i < `NUM_LINES; i++) begin
			if (rx_valid[i]) begin
				r_next.rx_data[i] = rx_byte[i];
				r_next.rx_full[i] = 1'b1;
				if (r_reg.rx_full[i]) begin
					r_next.ovr[i] = 1'b1;
					ev[4*i+1] = 1'b1;
				end
				if (rx_fe[i]) begin
					r_next.fe[i] = 1'b1;
					ev[4*i+2] = 1'b1;
				end
				if (rx_pe[i]) begin
					r_next.pe[i] = 1'b1;
					ev[4*i+3] = 1'b1;
				end
				ev[4*i] = 1'b1;
			end
		end
		// Register access in the setup cycle
		if (setup) begin
			if (paddr_in[7]) begin
				unique case (paddr_in)
					`OFS_IRQ_STAT: r_next.rdata = {16'h0000, r_reg.irq_stat};
					`OFS_IRQ_MASK: r_next.rdata = {16'h0000, r_reg.irq_mask};
					`OFS_ID: r_next.rdata = {24'h000000, `ID_VALUE}; // Arbitrary value
					default: begin
						r_next.rdata = 32'h00000000;
						r_next.err = 1'b1;
					end
				endcase
				if (pwrite_in && paddr_in == `OFS_IRQ_STAT)
					r_next.irq_stat = r_reg.irq_stat & ~pwdata_in[15:0];
				if (pwrite_in && paddr_in == `OFS_IRQ_MASK)
					r_next.irq_mask = pwdata_in[15:0];
			end else begin
				// Status: mark bits fixed at one, CTS follows RTS
				unique case ({3'h0, ofs})
					`OFS_DATA: rd = r_reg.rx_data[line_sel];
					`OFS_CTRL: rd = r_reg.ctrl[line_sel];
					`OFS_SPEED: rd = r_reg.speed[line_sel];
					`OFS_CFG: rd = r_reg.cfg[line_sel];
					`OFS_STAT: rd = {r_reg.fe[line_sel], r_reg.ovr[line_sel],
						r_reg.pe[line_sel], !tx_busy[line_sel], 2'b11,
						r_reg.ctrl[line_sel][`CTRL_RTS], 1'b1};
					default: r_next.err = 1'b1;
				endcase
				r_next.rdata = {24'h000000, rd};
				// Reading the character frees the holding register
				if (!pwrite_in && {3'h0, ofs} == `OFS_DATA)
					r_next.rx_full[line_sel] = rx_valid[line_sel];
				if (pwrite_in) begin
					unique case ({3'h0, ofs})
						`OFS_CTRL: r_next.ctrl[line_sel] = pwdata_in[7:0];
						`OFS_SPEED: r_next.speed[line_sel] = pwdata_in[7:0];
						`OFS_CFG: r_next.cfg[line_sel] = pwdata_in[7:0];
						// Writing status sets parity controls and clears the error bits written as one
						`OFS_STAT: begin
							r_next.par[line_sel] = pwdata_in[7:0];
							// Writing one clears an error; new event wins
							if (pwdata_in[`STAT_OVERRUN] && !ev[4*line_sel+1])
								r_next.ovr[line_sel] = 1'b0;
							if (pwdata_in[`STAT_FRAMING] && !ev[4*line_sel+2])
								r_next.fe[line_sel] = 1'b0;
							if (pwdata_in[`STAT_RX_FULL] && !ev[4*line_sel+3])
								r_next.pe[line_sel] = 1'b0;
						end
						default: ;
					endcase
				end
			end
		end
		// Sticky events: set wins over a clear in the same cycle
		r_next.irq_stat = r_next.irq_stat | ev;
		r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
	end

	// Register update
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			r_reg <= '0;
			r_reg.ctrl <= {4{`CTRL_RESET}};
			r_reg.speed <= {4{`SPEED_RESET}};
			r_reg.cfg <= {4{`CFG_RESET}};
			r_reg.par <= {4{`PAR_RESET}};
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata_out = r_reg.rdata;
	assign pready_out = r_reg.ready;
	assign pslverr_out = r_reg.err;
	assign irq_out = r_reg.irq;
endmodule : async_line_adapter

// *** bench/line_adapter_checker.sv ***
// Purpose: port-level checks of the four-line serial adapter
// Assumes: zero-wait APB slave, one clock domain
// Notes: attached to the top module by bind below
`timescale 1ns/1ps
`include "line_adapter_cfg.svh"
module line_adapter_checker (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// APB
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// Lines and interrupt
	input wire logic [3:0] rxd_in,
	input wire logic [3:0] txd_out,
	input wire logic irq_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	// Address decode as the map defines it
	function automatic logic mapped(input logic [7:0] a);
		if (a >= 8'h80) begin
			return a inside {8'h80, 8'h84, 8'h88};
		end
		return a[4:0] inside {5'h04, 5'h08, 5'h10, 5'h14, 5'h18};
	endfunction : mapped
	// Bus phases
	sequence setup_s;
		psel_in && !penable_in;
	endsequence
	sequence access_s;
		psel_in && penable_in && pready_out;
	endsequence
	a_ready_next: assert property (setup_s |=> pready_out)
		else $error("no ready after setup");
	a_ready_once: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (pready_out |-> $past(psel_in && !penable_in))
		else $error("ready without setup");
	a_decode_err: assert property (setup_s |=> pslverr_out == !mapped(paddr_in))
		else $error("error flag does not match decode");
	a_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("error flag without ready");
	a_id_read: assert property (setup_s ##0 (!pwrite_in && paddr_in == `OFS_ID)
		|=> prdata_out == {24'h000000, `ID_VALUE})
		else $error("identity value wrong");
	a_upper_zero: assert property (access_s ##0 !pwrite_in
		|-> prdata_out[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_idle_reset: assert property ($fell(reset_in) |-> (txd_out == 4'hF) [*4])
		else $error("line not at mark after reset");
	a_mask_off: assert property (setup_s ##0 (pwrite_in && paddr_in == `OFS_IRQ_MASK
		&& pwdata_in[15:0] == 16'h0000) |-> ##[1:3] !irq_out)
		else $error("interrupt stays with mask cleared");
	a_start_hold: assert property ($fell(txd_out[0]) |=> !txd_out[0] [*8])
		else $error("start bit too short");
endmodule : line_adapter_checker
bind async_line_adapter line_adapter_checker chk (.sys_clk_in(sys_clk_in),
	.reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.rxd_in(rxd_in), .txd_out(txd_out), .irq_out(irq_out));

// *** bench/remote_terminal.sv ***
// Purpose: remote terminal at the far end of one serial line
// Assumes: bit time given in system clocks
// Notes: sends a bad stop only when a test asks for one
`timescale 1ns/1ps
module remote_terminal #(
	parameter int BIT_CLKS = 1296 // Clocks per bit
) (
	// Clock
	input wire logic clk_in,
	// Serial line
	input wire logic line_in,
	output logic line_out
);
	int rx_bits = 8; // Size expected from the adapter
	int rx_count = 0; // Characters taken
	logic [7:0] last_char = 8'h00; // Last character taken
	initial line_out = 1'b1; // Mark until first frame
	// Frame one character; stop level chosen by the caller
	task automatic send(input logic [7:0] d, input int n, input logic stop);
		@(posedge clk_in);
		line_out <= 1'b0; // Start bit
		repeat (BIT_CLKS) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			line_out <= d[i]; // LSB first
			repeat (BIT_CLKS) @(posedge clk_in);
		end
		line_out <= stop; // Low only for a framing test
		repeat (BIT_CLKS) @(posedge clk_in);
		line_out <= 1'b1; // Back to mark
	endtask : send
	// Take characters at bit centres, start confirmed mid-bit
	initial forever begin
		@(posedge clk_in);
		if (line_in === 1'b0) begin
			repeat (BIT_CLKS / 2) @(posedge clk_in);
			if (line_in === 1'b0) begin
				last_char = 8'h00;
				for (int i = 0; i < rx_bits; i++) begin
					repeat (BIT_CLKS) @(posedge clk_in);
					last_char[i] = line_in;
				end
				repeat (BIT_CLKS) @(posedge clk_in);
				rx_count++;
			end
		end
	end
endmodule : remote_terminal

// *** bench/async_line_adapter_test.sv ***
// Purpose: self-checking bench of the four-line adapter
// Assumes: speed code F, terminals model the far ends
// Notes: about 60k clocks in all
`timescale 1ns/1ps
`include "line_adapter_cfg.svh"
module async_line_adapter_test import line_adapter_pkg::*;;
	localparam int BIT_CLKS = 16 * (`CLK_HZ / (16 * 19200)); // One bit at code F
	logic sys_clk = 1'b0; // 25 MHz
	logic reset = 1'b1; // Held at start
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB control
	logic [7:0] paddr = 8'h00; // APB address
	logic [31:0] pwdata = 32'h0, prdata, rd; // APB data
	logic pready, pslverr, irq, err; // Answers
	wire logic [3:0] rxd; // From terminals
	logic [3:0] txd; // To terminals
	int n_fail = 0, samples_checked = 0; // Counters
	initial forever #20 sys_clk = ~sys_clk;
	async_line_adapter uut (.sys_clk_in(sys_clk), .reset_in(reset), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.rxd_in(rxd), .txd_out(txd), .irq_out(irq));
	// One terminal per line
	for (genvar i = 0; i < 4; i++) begin : g_line
		remote_terminal #(.BIT_CLKS(BIT_CLKS)) term (.clk_in(sys_clk), .line_in(txd[i]),
			.line_out(rxd[i]));
	end
	// Verdict and end of run
	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// Compare one value
	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	// One APB transfer; waits a bounded time for ready
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) check(32'h0, 32'h1, "no ready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Read and compare
	task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(rd, exp, what);
	endtask : rchk
	// Hang guard well past the expected run
	initial begin
		repeat (90000) @(posedge sys_clk);
		check(32'h0, 32'h1, "timeout");
		summarize();
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		check({28'h0, txd}, 32'hF, "idle lines");
		rchk(`OFS_CTRL, 32'h00, "ctrl reset");
		rchk(`OFS_SPEED, 32'hE0, "speed reset");
		rchk(`OFS_CFG, 32'h03, "cfg reset");
		rchk(`OFS_STAT, 32'h1D, "status reset");
		rchk(`OFS_ID, {24'h0, `ID_VALUE}, "id");
		apb(1'b0, 8'h1C, 32'h0);
		check({31'h0, err}, 32'h1, "unmapped");
		$display("test reset done");
		// Lines 0 and 1 set up before use: code F, line 1 five-bit
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, 8'(i * 32) + `OFS_SPEED, 32'hF0);
			apb(1'b1, 8'(i * 32) + `OFS_CFG, i ? 32'h00 : 32'h03);
			apb(1'b1, 8'(i * 32) + `OFS_CTRL, 32'hC0);
		end
		g_line[1].term.rx_bits = 5;
		apb(1'b1, `OFS_IRQ_MASK, 32'h1);
		apb(1'b1, `OFS_DATA, 32'hA5);
		apb(1'b1, 8'h20 + `OFS_DATA, 32'h6A);
		g_line[0].term.send(8'h3C, 8, 1'b1);
		repeat (3 * BIT_CLKS) @(posedge sys_clk);
		check(32'(g_line[0].term.last_char), 32'hA5, "sent char");
		check(32'(g_line[1].term.last_char), 32'h0A, "five bits");
		check(32'(g_line[1].term.rx_count), 32'h1, "one frame");
		check({31'h0, irq}, 32'h1, "irq raised");
		rchk(`OFS_IRQ_STAT, 32'h1, "rx event");
		rchk(`OFS_DATA, 32'h3C, "rx char");
		apb(1'b1, `OFS_IRQ_STAT, 32'h1);
		repeat (3) @(posedge sys_clk);
		check({31'h0, irq}, 32'h0, "irq cleared");
		$display("test duplex done");
		// Unread char overwritten by one with a bad stop
		g_line[0].term.send(8'h55, 8, 1'b1);
		g_line[0].term.send(8'h81, 8, 1'b0);
		repeat (4) @(posedge sys_clk);
		rchk(`OFS_STAT, 32'hDD, "overrun framing");
		rchk(`OFS_IRQ_STAT, 32'h7, "error events");
		rchk(`OFS_DATA, 32'h81, "newest char");
		check({31'h0, irq}, 32'h1, "irq pending");
		apb(1'b1, `OFS_IRQ_MASK, 32'h0);
		repeat (3) @(posedge sys_clk);
		check({31'h0, irq}, 32'h0, "irq masked");
		apb(1'b1, `OFS_STAT, 32'hC0);
		rchk(`OFS_STAT, 32'h1D, "errors cleared");
		apb(1'b1, `OFS_IRQ_STAT, 32'h7);
		rchk(`OFS_IRQ_STAT, 32'h0, "events cleared");
		$display("test errors done");
		// Options: 1.5 stops, parity, loop, mark and break on spare lines
		apb(1'b1, 8'h20 + `OFS_CFG, 32'h10);
		apb(1'b1, `OFS_STAT, 32'h0C);
		apb(1'b1, 8'h40 + `OFS_SPEED, 32'hF0);
		apb(1'b1, 8'h40 + `OFS_CFG, 32'h13);
		apb(1'b1, 8'h40 + `OFS_STAT, 32'h0C);
		apb(1'b1, 8'h40 + `OFS_CTRL, 32'hE2);
		apb(1'b1, 8'h60 + `OFS_SPEED, 32'hF0);
		apb(1'b1, 8'h60 + `OFS_CTRL, 32'h90);
		apb(1'b1, 8'h60 + `OFS_DATA, 32'h00);
		apb(1'b1, 8'h40 + `OFS_DATA, 32'h96);
		apb(1'b1, 8'h20 + `OFS_DATA, 32'h15);
		fork
			g_line[0].term.send(8'h03, 8, 1'b1);
			begin
				// Five bits and 1.5 stops: idle 9641 to 9721 clocks after the write
				repeat (9400) @(posedge sys_clk);
				rchk(8'h20 + `OFS_STAT, 32'h0D, "still sending");
				rchk(8'h40 + `OFS_STAT, 32'h0F, "cts follows rts");
				check({31'h0, txd[3]}, 32'h1, "mark held");
				check({31'h0, txd[2]}, 32'h1, "loop at mark");
				repeat (500) @(posedge sys_clk);
				rchk(8'h20 + `OFS_STAT, 32'h1D, "half stop done");
			end
		join
		repeat (BIT_CLKS) @(posedge sys_clk);
		rchk(`OFS_STAT, 32'h3D, "parity error");
		rchk(`OFS_DATA, 32'h03, "parity char");
		rchk(8'h40 + `OFS_DATA, 32'h96, "looped char");
		rchk(`OFS_IRQ_STAT, 32'h109, "option events");
		check(32'(g_line[1].term.last_char), 32'h15, "short char");
		check(32'(g_line[2].term.rx_count + g_line[3].term.rx_count), 32'h0, "pins quiet");
		apb(1'b1, 8'h60 + `OFS_CTRL, 32'h18);
		repeat (3) @(posedge sys_clk);
		check({31'h0, txd[3]}, 32'h0, "break over mark");
		apb(1'b1, 8'h60 + `OFS_CTRL, 32'h00);
		repeat (3) @(posedge sys_clk);
		check({31'h0, txd[3]}, 32'h1, "break released");
		$display("test options done");
		summarize();
	end
endmodule : async_line_adapter_test
